// File: common/esi_pkg.sv
package esi_pkg;
  // Opcode patterns, compared on the upper bits of the fetched word; the call pattern on the whole word
  localparam logic [15:0] ESI_OP_REG_CALL = 16'h0014;
  localparam logic [7:0] ESI_OP_PTR_SUB = 8'hE9;
  localparam logic [7:0] ESI_OP_PUSH_LIT = 8'hEA;
  localparam logic [7:0] ESI_OP_MOVE = 8'hEB;
  localparam logic [3:0] ESI_OP_SECOND = 4'hF;
  // Field positions
  localparam int ESI_MOVE_KIND_BIT = 7;
  localparam int ESI_PTR_SEL_LSB = 6;
  localparam logic [1:0] ESI_PTR_SEL_RETURN = 2'h3;
  localparam logic [11:0] ESI_PC_STEP = 12'h002;
  // Special register addresses in the data space
  localparam logic [11:0] ESI_ADDR_PC_LOW = 12'hFF9;
  localparam logic [11:0] ESI_ADDR_TOP_LOW = 12'hFFD;
  localparam logic [11:0] ESI_ADDR_TOP_HIGH = 12'hFFE;
  localparam logic [11:0] ESI_ADDR_TOP_UPPER = 12'hFFF;
  localparam logic [11:0] ESI_ADDR_IND0 = 12'hFEB;
  localparam logic [11:0] ESI_ADDR_IND1 = 12'hFE3;
  localparam logic [11:0] ESI_ADDR_IND2 = 12'hFDB;
  localparam logic [2:0] ESI_IND_SPAN = 3'h4;
  localparam logic [11:0] ESI_PTR_RESET = 12'h000;
  localparam logic [7:0] ESI_ZERO_BYTE = 8'h00;

  typedef enum logic [2:0] {
    ESI_IDLE,
    ESI_CALL_WAIT,
    ESI_RET_WAIT,
    ESI_MOVE_ABS,
    ESI_MOVE_IDX
  } esi_state_t;

  // Data memory request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } esi_mem_req_t;

  // Program counter / return stack request
  typedef struct packed {
    logic push;
    logic pop_load;
    logic load;
    logic [20:0] push_addr;
    logic [20:0] target;
  } esi_flow_req_t;
endpackage

// File: design/esi_core.sv
`timescale 1ns/100ps
// How it works
// - Register call pushes PC+2, loads PC
// - Register call: one word, two cycles
// - Register call changes only stack and PC
// - Absolute move source is pointer plus offset
// - Absolute move destination is 12-bit address
// - Moves never write PC or stack-top bytes
// - Indirect-register source reads as zero
// - Indexed move adds two offsets to pointer
// - Indirect destination blocks indexed move write
// - Push literal stores then decrements pointer
// - Pointer subtract 6-bit literal, flags untouched
// - Selector three means subtract and return
// - Then load PC from return stack top
// - Subtract and return takes two cycles
// - Extended set needs configuration bit set
module esi_core
  import esi_pkg::*;
#(
  parameter int PTR_W = 12
)
(
  input wire logic clk_sys, // 40 MHz core clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic extended_set_config_bit, // Configuration strap
  input wire logic insn_valid, // Fetched word is valid this cycle
  input wire logic [15:0] insn_word, // Fetched instruction word
  input wire logic [20:0] pc_now, // Address of the current instruction
  input wire logic [7:0] working_register, // Working register value
  input wire logic [7:0] pc_high_latch, // High byte latch
  input wire logic [7:0] pc_upper_latch, // Upper byte latch
  input wire logic [7:0] mem_rdata, // Data memory read byte, same cycle
  output esi_pkg::esi_mem_req_t mem_req_q, // Data memory request
  output esi_pkg::esi_flow_req_t flow_req_q, // PC and return stack request
  output logic insn_busy_q, // Second cycle of a two-cycle op
  output logic insn_taken_q, // Word was an extended instruction
  output logic [PTR_W-1:0] soft_stack_pointer_q, // Pointer 2
  output logic [PTR_W-1:0] file_select_pointer0_q, // Pointer 0
  output logic [PTR_W-1:0] file_select_pointer1_q // Pointer 1
);
  import esi_pkg::*;

  // Only the 12-bit data space is decoded
  if (PTR_W != 12)
  begin : g_width_check
    $error("esi_core: pointer width must be 12");
  end

  function automatic logic is_indirect(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    if (a >= ESI_ADDR_IND0 && a < ESI_ADDR_IND0 + 12'(ESI_IND_SPAN))
      hit = 1'b1;
    if (a >= ESI_ADDR_IND1 && a < ESI_ADDR_IND1 + 12'(ESI_IND_SPAN))
      hit = 1'b1;
    if (a >= ESI_ADDR_IND2 && a < ESI_ADDR_IND2 + 12'(ESI_IND_SPAN))
      hit = 1'b1;
    // The indirect window is five bytes: four listed above plus the plus-w slot
    if (a == ESI_ADDR_IND0 + 12'(ESI_IND_SPAN) || a == ESI_ADDR_IND1 + 12'(ESI_IND_SPAN)
        || a == ESI_ADDR_IND2 + 12'(ESI_IND_SPAN))
      hit = 1'b1;
    return hit;
  endfunction

  function automatic logic is_protected(input logic [11:0] a);
    return a == ESI_ADDR_PC_LOW || a == ESI_ADDR_TOP_LOW
      || a == ESI_ADDR_TOP_HIGH || a == ESI_ADDR_TOP_UPPER;
  endfunction

  esi_state_t state_q, state_d;
  logic [7:0] move_data_q;
  logic [11:0] move_src_q;

  // Extended set gate
  // config bit gates
  logic cfg_s1_q, cfg_q;
  wire ext_on = cfg_q;
  wire idle = state_q == ESI_IDLE;
  wire dec = idle && insn_valid && ext_on;
  wire [7:0] op_hi = insn_word[15:8];
  wire is_call = dec && insn_word == ESI_OP_REG_CALL;
  wire is_push = dec && op_hi == ESI_OP_PUSH_LIT;
  wire is_sub = dec && op_hi == ESI_OP_PTR_SUB;
  wire [1:0] sel = insn_word[ESI_PTR_SEL_LSB +: 2];
  wire is_subret = is_sub && sel == ESI_PTR_SEL_RETURN;
  wire is_move = dec && op_hi == ESI_OP_MOVE;
  wire move_idx = insn_word[ESI_MOVE_KIND_BIT];
  wire [11:0] k6 = {6'h00, insn_word[5:0]};
  wire [11:0] z7 = {5'h00, insn_word[6:0]};
  wire [11:0] src_addr = soft_stack_pointer_q + z7;
  wire [11:0] dst_idx = soft_stack_pointer_q + z7;
  wire [11:0] dst_abs = insn_word[11:0];
  wire second_ok = insn_valid && insn_word[15:12] == ESI_OP_SECOND;
  wire [11:0] dst_addr = state_q == ESI_MOVE_IDX ? dst_idx : dst_abs;
  wire in_move = state_q == ESI_MOVE_ABS || state_q == ESI_MOVE_IDX;
  wire move_write = in_move && second_ok && !is_protected(dst_addr)
    && !(state_q == ESI_MOVE_IDX && is_indirect(dst_addr));
  wire [7:0] src_val = is_indirect(src_addr) ? ESI_ZERO_BYTE : mem_rdata;
  // call target from working register and latches
  wire [20:0] call_target = {pc_upper_latch[4:0], pc_high_latch, working_register};

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ESI_IDLE:
      begin
        if (is_call)
          state_d = ESI_CALL_WAIT;
        else if (is_subret)
          state_d = ESI_RET_WAIT;
        else if (is_move)
          state_d = move_idx ? ESI_MOVE_IDX : ESI_MOVE_ABS;
      end
      ESI_CALL_WAIT,
      ESI_RET_WAIT:
        state_d = ESI_IDLE;
      ESI_MOVE_ABS,
      ESI_MOVE_IDX:
        if (insn_valid)
          state_d = ESI_IDLE;
      default:
        state_d = ESI_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cfg_s1_q <= 1'b0;
      cfg_q <= 1'b0;
      state_q <= ESI_IDLE;
      move_data_q <= ESI_ZERO_BYTE;
      move_src_q <= ESI_PTR_RESET;
    end
    else
    begin
      cfg_s1_q <= extended_set_config_bit;
      cfg_q <= cfg_s1_q;
      state_q <= state_d;
      if (is_move)
      begin
        move_data_q <= src_val;
        move_src_q <= src_addr;
      end
    end
  end

  // Pointer updates land at the end of the cycle, so the next word sees them
  // immediate commit
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      soft_stack_pointer_q <= ESI_PTR_RESET;
      file_select_pointer0_q <= ESI_PTR_RESET;
      file_select_pointer1_q <= ESI_PTR_RESET;
    end
    else if (is_push)
      soft_stack_pointer_q <= soft_stack_pointer_q - 12'h001;
    else if (is_sub)
    begin
      case (sel)
        2'h0: file_select_pointer0_q <= file_select_pointer0_q - k6;
        2'h1: file_select_pointer1_q <= file_select_pointer1_q - k6;
        default: soft_stack_pointer_q <= soft_stack_pointer_q - k6;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mem_req_q <= '0;
      flow_req_q <= '0;
      insn_busy_q <= 1'b0;
      insn_taken_q <= 1'b0;
    end
    else
    begin
      mem_req_q <= '0;
      flow_req_q <= '0;
      insn_busy_q <= state_d != ESI_IDLE;
      insn_taken_q <= is_call || is_push || is_sub || is_move;
      if (is_push)
      begin
        mem_req_q.wr <= 1'b1;
        mem_req_q.addr <= soft_stack_pointer_q;
        mem_req_q.wdata <= insn_word[7:0];
      end
      else if (is_move)
      begin
        mem_req_q.rd <= 1'b1;
        mem_req_q.addr <= src_addr;
      end
      else if (move_write)
      begin
        mem_req_q.wr <= 1'b1;
        mem_req_q.addr <= dst_addr;
        mem_req_q.wdata <= move_data_q;
      end
      // push return address and jump; nothing else touched
      if (is_call)
      begin
        flow_req_q.push <= 1'b1;
        flow_req_q.push_addr <= pc_now + 21'(ESI_PC_STEP);
        flow_req_q.load <= 1'b1;
        flow_req_q.target <= call_target;
      end
      if (is_subret)
        flow_req_q.pop_load <= 1'b1;
    end
  end
endmodule

// File: verification/esi_core_checker.sv
`timescale 1ns/100ps
module esi_core_checker
#(
  parameter int PTR_W = 12
)
(
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic extended_set_config_bit, // Strap
  input wire logic insn_valid, // Valid
  input wire logic [15:0] insn_word, // Word
  input wire logic [20:0] pc_now, // PC
  input wire logic [7:0] working_register, // W
  input wire logic [7:0] pc_high_latch, // High latch
  input wire logic [7:0] pc_upper_latch, // Upper latch
  input wire logic [7:0] mem_rdata, // Read data
  input esi_pkg::esi_mem_req_t mem_req_q, // Memory
  input esi_pkg::esi_flow_req_t flow_req_q, // Flow
  input wire logic insn_busy_q, // Busy
  input wire logic insn_taken_q, // Taken
  input wire logic [PTR_W-1:0] soft_stack_pointer_q, // Stack pointer
  input wire logic [PTR_W-1:0] file_select_pointer0_q, // Pointer 0
  input wire logic [PTR_W-1:0] file_select_pointer1_q // Pointer 1
);
  import esi_pkg::*;
  logic [2:0] cfg_h;
  // Strap history, so decode is only expected once the synchroniser is surely high
  always_ff @(posedge clk_sys)
    cfg_h <= rst ? 3'h0 : {cfg_h[1:0], extended_set_config_bit};
  wire go = !insn_busy_q && insn_valid && (&cfg_h) && extended_set_config_bit;
  wire [7:0] op = insn_word[15:8];
  wire [7:0] lit = insn_word[7:0];
  wire [5:0] k6 = insn_word[5:0];
  wire [11:0] dst = insn_word[11:0];
  wire prot = dst == ESI_ADDR_PC_LOW || dst >= ESI_ADDR_TOP_LOW;
  wire [20:0] call_tgt = {pc_upper_latch[4:0], pc_high_latch, working_register};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  chk_push_store: assert property (go && op == ESI_OP_PUSH_LIT |=> mem_req_q.wr
    && mem_req_q.addr == $past(soft_stack_pointer_q) && mem_req_q.wdata == $past(lit)
    && soft_stack_pointer_q == $past(soft_stack_pointer_q) - 1'b1) else $error("push wrong");
  chk_call_flow: assert property (go && insn_word == ESI_OP_REG_CALL |=> flow_req_q.push
    && flow_req_q.load && flow_req_q.push_addr == $past(pc_now) + 21'h000002
    && flow_req_q.target == $past(call_tgt)) else $error("call flow wrong");
  chk_call_cycles: assert property (go && insn_word == ESI_OP_REG_CALL |=> insn_busy_q
    && !mem_req_q.wr && $stable(soft_stack_pointer_q) ##1 !insn_busy_q) else $error("call cycles");
  chk_sub_ptr: assert property (go && op == ESI_OP_PTR_SUB && insn_word[7:6] == 2'h1 |=>
    file_select_pointer1_q == $past(file_select_pointer1_q) - $past(k6)
    && $stable(soft_stack_pointer_q)) else $error("pointer subtract wrong");
  chk_subret_pop: assert property (go && op == ESI_OP_PTR_SUB && insn_word[7:6] == 2'h3 |=>
    flow_req_q.pop_load && insn_busy_q && soft_stack_pointer_q == $past(soft_stack_pointer_q)
    - $past(k6) ##1 !insn_busy_q) else $error("subtract and return wrong");
  chk_gate_off: assert property (!extended_set_config_bit && !(|cfg_h) |=>
    !insn_taken_q && !mem_req_q.wr) else $error("decoded while disabled");
  chk_move_read: assert property (go && op == ESI_OP_MOVE |=> mem_req_q.rd && insn_busy_q)
    else $error("move read missing");
  chk_move_abs: assert property (go && op == ESI_OP_MOVE && !insn_word[7] ##1 insn_valid
    && insn_word[15:12] == ESI_OP_SECOND && !prot |=> mem_req_q.wr && mem_req_q.addr == $past(dst))
    else $error("absolute move write wrong");
  chk_move_guard: assert property (go && op == ESI_OP_MOVE && !insn_word[7] ##1 insn_valid
    && prot |=> !mem_req_q.wr) else $error("protected destination written");
endmodule

// File: verification/esi_core_tb.sv
`timescale 1ns/100ps
module esi_core_tb;
  import esi_pkg::*;
  localparam int PTR_W = 12;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic extended_set_config_bit = 1'b0;
  logic insn_valid = 1'b0;
  logic [15:0] insn_word = 16'h0000;
  logic [20:0] pc_now = 21'h000100;
  logic [7:0] working_register = 8'h06;
  logic [7:0] pc_high_latch = 8'h10;
  logic [7:0] pc_upper_latch = 8'h00;
  logic [7:0] mem_rdata = 8'h33;
  esi_mem_req_t mem_req_q;
  esi_flow_req_t flow_req_q;
  logic insn_busy_q;
  logic insn_taken_q;
  logic [PTR_W-1:0] soft_stack_pointer_q;
  logic [PTR_W-1:0] file_select_pointer0_q;
  logic [PTR_W-1:0] file_select_pointer1_q;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  esi_core #(.PTR_W(PTR_W)) DUT (
    .clk_sys(clk_sys),
    .rst(rst),
    .extended_set_config_bit(extended_set_config_bit),
    .insn_valid(insn_valid),
    .insn_word(insn_word),
    .pc_now(pc_now),
    .working_register(working_register),
    .pc_high_latch(pc_high_latch),
    .pc_upper_latch(pc_upper_latch),
    .mem_rdata(mem_rdata),
    .mem_req_q(mem_req_q),
    .flow_req_q(flow_req_q),
    .insn_busy_q(insn_busy_q),
    .insn_taken_q(insn_taken_q),
    .soft_stack_pointer_q(soft_stack_pointer_q),
    .file_select_pointer0_q(file_select_pointer0_q),
    .file_select_pointer1_q(file_select_pointer1_q)
  );
  always #12.5 clk_sys = ~clk_sys;
  task close_out;
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // The whole run needs well under a hundred cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  task cmp(input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Word is taken at the next edge; outputs are sampled just after it
  task put(input logic [15:0] w);
    insn_valid <= 1'b1;
    insn_word <= w;
    @(posedge clk_sys);
    insn_valid <= 1'b0;
    #1;
  endtask
  task s_gate;
    put(16'hEA55);
    cmp(insn_taken_q, 1'b0);
    cmp(mem_req_q.wr, 1'b0);
  endtask
  task s_ptr;
    put(16'hE901);
    put(16'hE942);
    put(16'hE9A3);
    cmp({file_select_pointer0_q, file_select_pointer1_q}, 24'hFFFFFE);
    cmp(soft_stack_pointer_q, 12'hFDD);
  endtask
  task s_push;
    put(16'hEA11);
    cmp({mem_req_q.wr, mem_req_q.addr, mem_req_q.wdata}, {1'b1, 12'hFDD, 8'h11});
    cmp(insn_taken_q, 1'b1);
    put(16'hEA22);
    cmp({mem_req_q.wr, mem_req_q.addr, mem_req_q.wdata}, {1'b1, 12'hFDC, 8'h22});
    cmp(soft_stack_pointer_q, 12'hFDB);
  endtask
  task s_call;
    put(16'h0014);
    cmp({flow_req_q.push, flow_req_q.load, insn_busy_q}, 3'b111);
    cmp(flow_req_q.push_addr, 21'h000102);
    cmp(flow_req_q.target, 21'h001006);
    cmp({mem_req_q.wr, soft_stack_pointer_q}, {1'b0, 12'hFDB});
    // A push offered in the wait cycle must be ignored
    put(16'hEA99);
    cmp({insn_busy_q, mem_req_q.wr, soft_stack_pointer_q}, {2'b00, 12'hFDB});
  endtask
  task s_subret;
    put(16'hE9C5);
    cmp({flow_req_q.pop_load, insn_busy_q}, 2'b11);
    cmp(soft_stack_pointer_q, 12'hFD6);
    put(16'hEA77);
    cmp({mem_req_q.wr, soft_stack_pointer_q}, {1'b0, 12'hFD6});
  endtask
  task move(input logic [15:0] w1, input logic [15:0] w2, input logic [11:0] src,
    input logic [20:0] exp);
    mem_rdata <= 8'h33;
    put(w1);
    cmp({mem_req_q.rd, insn_busy_q}, 2'b11);
    cmp(mem_req_q.addr, src);
    mem_rdata <= 8'h5A;
    put(w2);
    cmp(mem_req_q.wr ? {mem_req_q.wr, mem_req_q.addr, mem_req_q.wdata} : 21'h0, exp);
  endtask
  task s_move;
    move(16'hEB00, 16'hF123, 12'hFD6, {1'b1, 12'h123, 8'h33});
    move(16'hEB00, 16'hFFFD, 12'hFD6, 21'h0);
    move(16'hEB00, 16'hFFF9, 12'hFD6, 21'h0);
    move(16'hEB15, 16'hF100, 12'hFEB, {1'b1, 12'h100, 8'h00});
    move(16'hEB81, 16'hF002, 12'hFD7, {1'b1, 12'hFD8, 8'h33});
    move(16'hEB81, 16'hF00D, 12'hFD7, 21'h0);
  endtask
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    s_gate();
    extended_set_config_bit <= 1'b1;
    repeat (3) put(16'h0000);
    s_ptr();
    s_push();
    s_call();
    s_subret();
    s_move();
    close_out();
  end
endmodule
bind esi_core esi_core_checker #(.PTR_W(PTR_W)) u_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .extended_set_config_bit(extended_set_config_bit),
  .insn_valid(insn_valid),
  .insn_word(insn_word),
  .pc_now(pc_now),
  .working_register(working_register),
  .pc_high_latch(pc_high_latch),
  .pc_upper_latch(pc_upper_latch),
  .mem_rdata(mem_rdata),
  .mem_req_q(mem_req_q),
  .flow_req_q(flow_req_q),
  .insn_busy_q(insn_busy_q),
  .insn_taken_q(insn_taken_q),
  .soft_stack_pointer_q(soft_stack_pointer_q),
  .file_select_pointer0_q(file_select_pointer0_q),
  .file_select_pointer1_q(file_select_pointer1_q)
);
